// *** verilog/tcd_regs.vh ***
// Register map, field layout, reset values and timing counts of the decoder.
`ifndef TCD_REGS_VH
`define TCD_REGS_VH
`define TCD_OFS_FILTER      32'h0000_0000
`define TCD_OFS_RUN_MODE    32'h0000_0004
`define TCD_OFS_MAX_FREQ    32'h0000_0008
`define TCD_OFS_ROUTE       32'h0000_000C
`define TCD_OFS_STATUS      32'h0000_0010
`define TCD_OFS_REF_OUT     32'h0000_0014
`define TCD_OFS_REF_BASE    32'h0000_0040
`define TCD_REF_SPAN        32'h0000_0040
`define TCD_FILTER_RST      16'h000A
`define TCD_FILTER_MAX      16'h03E8
`define TCD_RUN_MODE_RST    16'h0000
`define TCD_MAX_FREQ_RST    16'h1388
`define TCD_ROUTE_RST       2'h0
`define TCD_MODE_2L1        2'h0
`define TCD_MODE_2L2        2'h1
`define TCD_MODE_3L1        2'h2
`define TCD_MODE_3L2        2'h3
`define TCD_ROUTE_SPEED     2'h0
`define TCD_ROUTE_PID       2'h1
`define TCD_ROUTE_VF        2'h2
`define TCD_MS_NS           1000000
`define TCD_CLK_PERIOD_NS   5
`define TCD_CYC_PER_MS      (`TCD_MS_NS / `TCD_CLK_PERIOD_NS)
`define TCD_FULL_SCALE      16'h2710
`define TCD_ST_RUN          0
`define TCD_ST_REV          1
`define TCD_ST_ACC_LSB      2
`define TCD_ST_MOT_LSB      4
`define TCD_ST_IDX_LSB      8
`define TCD_ST_TERM_LSB     16
`endif

// *** verilog/tcd_filter.v ***
// Debounce filter for one terminal input.
`timescale 1ns/1ps
module tcd_filter
#(
  parameter CYC_PER_MS = 200000
)
(
  input  wire        core_clk,   // Control clock.
  input  wire        rst_b,      // Asynchronous reset, active low.
  input  wire        clk_en,     // State freezes while low.
  input  wire        tick_ms,    // One-cycle pulse per millisecond.
  input  wire [15:0] filt_ms,    // Filter time in milliseconds.
  input  wire        raw_in,     // Raw terminal level.
  output reg         clean_out   // Accepted terminal level.
);
  reg [15:0] cnt_r;

  // A level is taken only after it has held for the full filter time;
  // any earlier return to the old level restarts the count.
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r     <= 16'h0000;
      clean_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (raw_in == clean_out)
        cnt_r <= 16'h0000;
      else if (filt_ms == 16'h0000)
        clean_out <= raw_in;
      else if (tick_ms)
      begin
        if (cnt_r >= filt_ms)
        begin
          clean_out <= raw_in;
          cnt_r     <= 16'h0000;
        end
        else
          cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule

// *** verilog/tcd_top.v ***
// Terminal command decoder with AHB-Lite register slave.
`timescale 1ns/1ps
`include "tcd_regs.vh"
module tcd_top
#(
  parameter CYC_PER_MS = `TCD_CYC_PER_MS,
  parameter NTERM      = 11
)
(
  input  wire        core_clk,      // Control clock, 200 MHz.
  input  wire        rst_b,         // Asynchronous reset, active low.
  input  wire        clk_en,        // Clock enable, freezes state when low.
  input  wire        hsel,          // AHB slave select.
  input  wire [31:0] haddr,         // AHB address.
  input  wire [1:0]  htrans,        // AHB transfer type.
  input  wire        hwrite,        // AHB write.
  input  wire [2:0]  hsize,         // AHB size.
  input  wire [31:0] hwdata,        // AHB write data.
  input  wire        hready,        // AHB bus ready.
  output reg  [31:0] hrdata,        // AHB read data.
  output reg         hreadyout,     // AHB slave ready.
  output reg         hresp,         // AHB response, always OKAY.
  input  wire        input_terminal_one,   // Terminal one raw.
  input  wire        input_terminal_two,   // Terminal two raw.
  input  wire        input_terminal_three, // Terminal three raw.
  input  wire        select_bit_zero,      // Reference select bit 0.
  input  wire        select_bit_one,       // Reference select bit 1.
  input  wire        select_bit_two,       // Reference select bit 2.
  input  wire        select_bit_three,     // Reference select bit 3.
  input  wire        acc_sel_one,          // Accel/decel select terminal 1.
  input  wire        acc_sel_two,          // Accel/decel select terminal 2.
  input  wire        motor_sel_one,        // Motor select terminal 1.
  input  wire        motor_sel_two,        // Motor select terminal 2.
  output reg         run_cmd,       // Run command level.
  output reg         reverse_cmd,   // Reverse direction level.
  output reg  [3:0]  ref_index,     // Selected reference index.
  output reg  [1:0]  acc_set,       // Accel/decel set minus one.
  output reg  [1:0]  motor_group,   // Motor group minus one.
  output reg  [15:0] speed_ref,     // Scaled reference as speed.
  output reg  [15:0] pid_setpoint,  // Scaled reference as PID setpoint.
  output reg  [15:0] vf_voltage     // Scaled reference as V/F voltage.
);
  reg  [15:0] input_filter_time_r;
  reg  [15:0] terminal_run_mode_r;
  reg  [15:0] max_output_frequency_r;
  reg  [1:0]  route_r;
  reg  [15:0] ref_mem [0:15];
  reg  [31:0] ms_cnt_r;
  reg         tick_ms_r;
  reg         ap_wr_r;
  reg  [7:0]  ap_addr_r;
  reg         t1_d_r;
  reg         rev_d_r;
  reg         run_nxt;
  reg         rev_nxt;
  reg  [15:0] scaled_nxt;
  reg  [31:0] rd_nxt;
  wire [NTERM-1:0] raw_w;
  wire [NTERM-1:0] flt_w;
  wire        f_t1;
  wire        f_t2;
  wire        f_t3;
  wire [3:0]  idx_w;
  wire        ap_valid;
  wire [1:0]  mode_w;
  integer     i;

  function [15:0] tcd_scale;
    input [15:0] pct;
    input [15:0] fmax;
    reg   [31:0] prod;
    reg   [31:0] quot;
    begin
      prod      = pct * fmax;
      quot      = prod / {16'h0000, `TCD_FULL_SCALE};
      tcd_scale = quot[15:0];
    end
  endfunction

  function [15:0] tcd_clip_filter;
    input [15:0] val;
    begin
      if (val > `TCD_FILTER_MAX)
        tcd_clip_filter = `TCD_FILTER_MAX;
      else
        tcd_clip_filter = val;
    end
  endfunction

  function tcd_is_ref;
    input [7:0] addr;
    begin
      tcd_is_ref = (addr >= `TCD_OFS_REF_BASE) &&
                   (addr < `TCD_OFS_REF_BASE + `TCD_REF_SPAN);
    end
  endfunction

  function tcd_is_wr;
    input [7:0] addr;
    begin
      tcd_is_wr = tcd_is_ref(addr) ||
                  (addr == `TCD_OFS_FILTER) ||
                  (addr == `TCD_OFS_RUN_MODE) ||
                  (addr == `TCD_OFS_MAX_FREQ) ||
                  (addr == `TCD_OFS_ROUTE);
    end
  endfunction

  // Read-back value of a word in the cycle its write lands.
  function [31:0] tcd_wr_view;
    input [7:0]  addr;
    input [31:0] data;
    begin
      tcd_wr_view = 32'h0000_0000;
      if (tcd_is_ref(addr))
        tcd_wr_view = {16'h0000, data[15:0]};
      else
        case ({24'h000000, addr})
          `TCD_OFS_FILTER:
            tcd_wr_view = {16'h0000, tcd_clip_filter(data[15:0])};
          `TCD_OFS_RUN_MODE:
            tcd_wr_view = {16'h0000, 14'h0000, data[1:0]};
          `TCD_OFS_MAX_FREQ:
            tcd_wr_view = {16'h0000, data[15:0]};
          `TCD_OFS_ROUTE:
            tcd_wr_view = {16'h0000, 14'h0000, data[1:0]};
          default:
            tcd_wr_view = 32'h0000_0000;
        endcase
    end
  endfunction

  assign raw_w = {motor_sel_two, motor_sel_one, acc_sel_two, acc_sel_one,
                  select_bit_three, select_bit_two, select_bit_one,
                  select_bit_zero, input_terminal_three, input_terminal_two,
                  input_terminal_one};

  // One shared millisecond tick keeps each filter counter at 16 bits.
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ms_cnt_r  <= 32'h0000_0000;
      tick_ms_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ms_cnt_r == CYC_PER_MS - 1)
      begin
        ms_cnt_r  <= 32'h0000_0000;
        tick_ms_r <= 1'b1;
      end
      else
      begin
        ms_cnt_r  <= ms_cnt_r + 32'h0000_0001;
        tick_ms_r <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NTERM; g = g + 1)
    begin : g_flt
      tcd_filter #(.CYC_PER_MS(CYC_PER_MS)) u_flt
      (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .tick_ms   (tick_ms_r),
        .filt_ms   (input_filter_time_r),
        .raw_in    (raw_w[g]),
        .clean_out (flt_w[g])
      );
    end
  endgenerate

  assign f_t1   = flt_w[0];
  assign f_t2   = flt_w[1];
  assign f_t3   = flt_w[2];
  assign idx_w  = flt_w[6:3];
  assign mode_w = terminal_run_mode_r[1:0];

  // Run decode per terminal command mode.
  always @*
  begin
    run_nxt = run_cmd;
    rev_nxt = reverse_cmd;
    case (mode_w)
      `TCD_MODE_2L1:
      begin
        run_nxt = f_t1 ^ f_t2;
        rev_nxt = f_t2 & ~f_t1;
      end
      `TCD_MODE_2L2:
      begin
        run_nxt = f_t1;
        rev_nxt = f_t1 & f_t2;
      end
      `TCD_MODE_3L1:
      begin
        // Stop relies on the enable being held during running.
        if (!f_t3)
          run_nxt = 1'b0;
        else if (f_t1 & ~t1_d_r)
        begin
          run_nxt = 1'b1;
          rev_nxt = 1'b0;
        end
        else if (f_t2 & ~rev_d_r)
        begin
          run_nxt = 1'b1;
          rev_nxt = 1'b1;
        end
      end
      `TCD_MODE_3L2:
      begin
        if (!f_t3)
          run_nxt = 1'b0;
        else if (f_t1 & ~t1_d_r)
          run_nxt = 1'b1;
        rev_nxt = f_t2;
      end
      default:
      begin
        run_nxt = 1'b0;
        rev_nxt = 1'b0;
      end
    endcase
  end

  always @*
  begin
    scaled_nxt = tcd_scale(ref_mem[idx_w], max_output_frequency_r);
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_cmd      <= 1'b0;
      reverse_cmd  <= 1'b0;
      t1_d_r       <= 1'b0;
      rev_d_r      <= 1'b0;
      ref_index    <= 4'h0;
      acc_set      <= 2'h0;
      motor_group  <= 2'h0;
      speed_ref    <= 16'h0000;
      pid_setpoint <= 16'h0000;
      vf_voltage   <= 16'h0000;
    end
    else if (clk_en)
    begin
      run_cmd     <= run_nxt;
      reverse_cmd <= rev_nxt;
      t1_d_r      <= f_t1;
      rev_d_r     <= f_t2;
      ref_index   <= idx_w;
      acc_set     <= flt_w[8:7];
      motor_group <= flt_w[10:9];
      speed_ref    <= (route_r == `TCD_ROUTE_SPEED) ? scaled_nxt : 16'h0000;
      pid_setpoint <= (route_r == `TCD_ROUTE_PID) ? scaled_nxt : 16'h0000;
      vf_voltage   <= (route_r == `TCD_ROUTE_VF) ? scaled_nxt : 16'h0000;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  // Read data is registered at the address phase so it stands in the data phase.
  assign ap_valid = hsel & hready & htrans[1];

  always @*
  begin
    rd_nxt = 32'h0000_0000;
    if (haddr[31:8] != 24'h000000)
      rd_nxt = 32'h0000_0000;
    else if (tcd_is_ref(haddr[7:0]))
      rd_nxt = {16'h0000, ref_mem[haddr[5:2]]};
    else
      case ({24'h000000, haddr[7:0]})
        `TCD_OFS_FILTER:   rd_nxt = {16'h0000, input_filter_time_r};
        `TCD_OFS_RUN_MODE: rd_nxt = {16'h0000, terminal_run_mode_r};
        `TCD_OFS_MAX_FREQ: rd_nxt = {16'h0000, max_output_frequency_r};
        `TCD_OFS_ROUTE:    rd_nxt = {16'h0000, 14'h0000, route_r};
        `TCD_OFS_STATUS:   rd_nxt = {5'h00, flt_w, 4'h0, ref_index,
                                     2'h0, motor_group, acc_set,
                                     reverse_cmd, run_cmd};
        `TCD_OFS_REF_OUT:  rd_nxt = {16'h0000, scaled_nxt};
        default:           rd_nxt = 32'h0000_0000;
      endcase
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      input_filter_time_r    <= `TCD_FILTER_RST;
      terminal_run_mode_r    <= `TCD_RUN_MODE_RST;
      max_output_frequency_r <= `TCD_MAX_FREQ_RST;
      route_r                <= `TCD_ROUTE_RST;
      for (i = 0; i < 16; i = i + 1)
        ref_mem[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      ap_wr_r   <= ap_valid & hwrite & (haddr[31:8] == 24'h000000);
      ap_addr_r <= haddr[7:0];
      if (ap_valid & ~hwrite)
      begin
        // A read right behind a write to the same word must see the new
        // value; the scaled reference still shows the old one that cycle.
        if (ap_wr_r && (haddr[31:8] == 24'h000000) &&
            (haddr[7:0] == ap_addr_r) && tcd_is_wr(ap_addr_r))
          hrdata <= tcd_wr_view(ap_addr_r, hwdata);
        else
          hrdata <= rd_nxt;
      end
      if (ap_wr_r)
      begin
        if (tcd_is_ref(ap_addr_r))
          ref_mem[ap_addr_r[5:2]] <= hwdata[15:0];
        else
          case ({24'h000000, ap_addr_r})
            `TCD_OFS_FILTER:
              input_filter_time_r <= tcd_clip_filter(hwdata[15:0]);
            `TCD_OFS_RUN_MODE:
              terminal_run_mode_r <= {14'h0000, hwdata[1:0]};
            `TCD_OFS_MAX_FREQ:
              max_output_frequency_r <= hwdata[15:0];
            `TCD_OFS_ROUTE:
              route_r <= hwdata[1:0];
            default:
              route_r <= route_r;
          endcase
      end
    end
  end
endmodule

// *** dv/tcd_top_assertions.sv ***
// Port-level checks of the terminal command decoder.
`timescale 1ns/1ps
module tcd_top_assertions
#(
  parameter CYC_PER_MS = 200000
)
(
  input wire        core_clk, rst_b, clk_en,     // Clock, reset, enable.
  input wire        hreadyout, hresp,            // Bus answer.
  input wire        input_terminal_one, input_terminal_two, // Run inputs.
  input wire        input_terminal_three,        // Enable input.
  input wire        select_bit_zero, select_bit_one,   // Index bits.
  input wire        select_bit_two, select_bit_three,  // Index bits.
  input wire        acc_sel_one, acc_sel_two,    // Ramp select.
  input wire        motor_sel_one, motor_sel_two, // Motor select.
  input wire        run_cmd, reverse_cmd,        // Run outputs.
  input wire [3:0]  ref_index,                   // Index output.
  input wire [1:0]  acc_set, motor_group,        // Group outputs.
  input wire [15:0] speed_ref, pid_setpoint, vf_voltage // Routed values.
);
  // Longest filter plus pipeline; any mode must have stopped by then.
  localparam int IDLE_LIM = 1001 * CYC_PER_MS + 4;
  reg  [31:0] idle_r;
  wire        busy_w;
  wire [3:0]  sel_w;
  assign busy_w = input_terminal_one | input_terminal_two
                | input_terminal_three;
  assign sel_w = {select_bit_three, select_bit_two, select_bit_one,
                  select_bit_zero};
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      idle_r <= 32'h0;
    else if (!clk_en || busy_w)
      idle_r <= 32'h0;
    else if (idle_r < IDLE_LIM)
      idle_r <= idle_r + 32'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_fwd_start;
    $rose(run_cmd) && !reverse_cmd;
  endsequence
  sequence s_rev_start;
    $rose(run_cmd) && reverse_cmd;
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("slave not ready");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_route_single:
    assert property ($onehot0({|speed_ref, |pid_setpoint, |vf_voltage}))
    else $error("reference on more than one route");
  a_index_map:
    assert property ($changed(ref_index) |-> ref_index == $past(sel_w, 2))
    else $error("index differs from select terminals");
  a_ramp_map:
    assert property ($changed(acc_set) |->
      acc_set == $past({acc_sel_two, acc_sel_one}, 2))
    else $error("ramp set differs from terminals");
  a_motor_map:
    assert property ($changed(motor_group) |->
      motor_group == $past({motor_sel_two, motor_sel_one}, 2))
    else $error("motor group differs from terminals");
  a_fwd_cause:
    assert property (s_fwd_start |-> $past(input_terminal_one, 2))
    else $error("forward start without terminal one");
  a_rev_cause:
    assert property (s_rev_start |-> $past(input_terminal_two, 2))
    else $error("reverse start without terminal two");
  a_idle_stop:
    assert property (idle_r >= IDLE_LIM |-> !run_cmd)
    else $error("running with all terminals idle");
endmodule
bind tcd_top tcd_top_assertions #(.CYC_PER_MS(CYC_PER_MS)) i_chk
(
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
  .hreadyout(hreadyout), .hresp(hresp),
  .input_terminal_one(input_terminal_one),
  .input_terminal_two(input_terminal_two),
  .input_terminal_three(input_terminal_three),
  .select_bit_zero(select_bit_zero), .select_bit_one(select_bit_one),
  .select_bit_two(select_bit_two), .select_bit_three(select_bit_three),
  .acc_sel_one(acc_sel_one), .acc_sel_two(acc_sel_two),
  .motor_sel_one(motor_sel_one), .motor_sel_two(motor_sel_two),
  .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .ref_index(ref_index),
  .acc_set(acc_set), .motor_group(motor_group), .speed_ref(speed_ref),
  .pid_setpoint(pid_setpoint), .vf_voltage(vf_voltage)
);

// *** dv/tcd_switches.sv ***
// Switch and push-button model for the decoder's terminal inputs.
`timescale 1ns/1ps
module tcd_switches
(
  input  wire       core_clk, // Control clock.
  output reg  [2:0] run_sw,   // Terminals three, two, one.
  output reg  [7:0] grp_sw    // Motor, ramp and index switches.
);
  initial
  begin
    run_sw = 3'h0;
    grp_sw = 8'h00;
  end
  // Contacts hold their level, so the enable stays on until opened.
  task set_run(input [2:0] v);
    @(posedge core_clk);
    run_sw <= v;
  endtask
  task set_grp(input [7:0] v);
    @(posedge core_clk);
    grp_sw <= v;
  endtask
endmodule

// *** dv/tcd_top_test.sv ***
// Self-checking bench for the terminal command decoder.
`timescale 1ns/1ps
`include "tcd_regs.vh"
module tcd_top_test;
  reg         core_clk, rst_b, clk_en, hsel, hwrite;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [31:0] haddr, hwdata, rd;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, run_cmd, reverse_cmd;
  wire [2:0]  run_sw;
  wire [7:0]  grp_sw;
  wire [3:0]  ref_index;
  wire [1:0]  acc_set, motor_group;
  wire [15:0] speed_ref, pid_setpoint, vf_voltage;
  integer     miscompares, n_checks;
  tcd_top #(.CYC_PER_MS(10)) i_tcd_top
  (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .input_terminal_one(run_sw[0]), .input_terminal_two(run_sw[1]),
    .input_terminal_three(run_sw[2]),
    .select_bit_zero(grp_sw[0]), .select_bit_one(grp_sw[1]),
    .select_bit_two(grp_sw[2]), .select_bit_three(grp_sw[3]),
    .acc_sel_one(grp_sw[4]), .acc_sel_two(grp_sw[5]),
    .motor_sel_one(grp_sw[6]), .motor_sel_two(grp_sw[7]),
    .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .ref_index(ref_index),
    .acc_set(acc_set), .motor_group(motor_group), .speed_ref(speed_ref),
    .pid_setpoint(pid_setpoint), .vf_voltage(vf_voltage)
  );
  tcd_switches i_tcd_switches
  (
    .core_clk(core_clk), .run_sw(run_sw), .grp_sw(grp_sw)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ahb(input w, input [31:0] a, input [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rchk(input [31:0] a, input [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask
  // Write then read the same word with no idle cycle between them.
  task ahb_pair(input [31:0] a, input [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Bounded wait; the direction is only judged when running is expected.
  task wait_run(input er, input ev);
    integer k;
    k = 0;
    while ((run_cmd !== er || (er && reverse_cmd !== ev)) && k < 40)
    begin
      @(posedge core_clk);
      k = k + 1;
    end
    chk("run_cmd", er, run_cmd);
    if (er)
      chk("reverse_cmd", ev, reverse_cmd);
  endtask
  task press(input [2:0] base, input [2:0] btn);
    i_tcd_switches.set_run(base | btn);
    repeat (3) @(posedge core_clk);
    i_tcd_switches.set_run(base);
  endtask
  task t_reset;
    rchk(`TCD_OFS_FILTER, 32'h0000_000A);
    rchk(`TCD_OFS_RUN_MODE, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0100, 32'h1234_5678);
    rchk(32'h0000_0100, 32'h0000_0000);
    ahb(1'b1, `TCD_OFS_FILTER, 32'h0000_07D0);
    rchk(`TCD_OFS_FILTER, 32'h0000_03E8);
    ahb_pair(`TCD_OFS_FILTER, 32'h0000_0064);
    chk("register", 32'h0000_0064, rd);
  endtask
  task t_filter;
    ahb(1'b1, `TCD_OFS_FILTER, 32'h0000_0001);
    press(3'h0, 3'h1);
    repeat (30)
    begin
      @(posedge core_clk);
      chk("run_cmd", 1'b0, run_cmd);
    end
    i_tcd_switches.set_run(3'h1);
    wait_run(1'b1, 1'b0);
    i_tcd_switches.set_run(3'h0);
    wait_run(1'b0, 1'b0);
    ahb(1'b1, `TCD_OFS_FILTER, 32'h0000_0000);
  endtask
  // Deselected or frozen cycles must leave the filter register untouched and run_cmd frozen.
  task t_gating;
    hsel <= 1'b0;
    ahb(1'b1, `TCD_OFS_FILTER, 32'h0000_0005);
    hsel <= 1'b1;
    rchk(`TCD_OFS_FILTER, 32'h0000_0000);
    clk_en <= 1'b0;
    ahb(1'b1, `TCD_OFS_FILTER, 32'h0000_0005);
    i_tcd_switches.set_run(3'h1);
    repeat (5) @(posedge core_clk);
    chk("run_cmd", 1'b0, run_cmd);
    clk_en <= 1'b1;
    wait_run(1'b1, 1'b0);
    rchk(`TCD_OFS_FILTER, 32'h0000_0000);
    i_tcd_switches.set_run(3'h0);
    wait_run(1'b0, 1'b0);
  endtask
  task t_two_line;
    integer m, c;
    for (m = 0; m < 2; m = m + 1)
    begin
      ahb(1'b1, `TCD_OFS_RUN_MODE, m);
      for (c = 1; c < 5; c = c + 1)
      begin
        i_tcd_switches.set_run({1'b0, c[1:0]});
        wait_run(m ? c[0] : c[0] ^ c[1], c[1]);
      end
    end
  endtask
  task t_three_line;
    ahb(1'b1, `TCD_OFS_RUN_MODE, 32'h0000_0002);
    i_tcd_switches.set_run(3'h4);
    repeat (6) @(posedge core_clk);
    chk("run_cmd", 1'b0, run_cmd);
    press(3'h4, 3'h1);
    wait_run(1'b1, 1'b0);
    repeat (6) @(posedge core_clk);
    chk("run_cmd", 1'b1, run_cmd);
    press(3'h4, 3'h2);
    wait_run(1'b1, 1'b1);
    i_tcd_switches.set_run(3'h0);
    wait_run(1'b0, 1'b0);
    ahb(1'b1, `TCD_OFS_RUN_MODE, 32'h0000_0003);
    press(3'h6, 3'h1);
    wait_run(1'b1, 1'b1);
    repeat (4) @(posedge core_clk);
    rchk(`TCD_OFS_STATUS, 32'h0006_0003);
    i_tcd_switches.set_run(3'h4);
    wait_run(1'b1, 1'b0);
    i_tcd_switches.set_run(3'h0);
    wait_run(1'b0, 1'b0);
  endtask
  task t_select;
    integer k;
    for (k = 0; k < 16; k = k + 1)
      ahb(1'b1, `TCD_OFS_REF_BASE + 4 * k, 16'h2710 - 16'h01F4 * k);
    for (k = 0; k < 16; k = k + 1)
    begin
      i_tcd_switches.set_grp({~k[1:0], k[1:0], k[3:0]});
      repeat (5) @(posedge core_clk);
      chk("ref_index", k, ref_index);
      chk("acc_set", k[1:0], acc_set);
      chk("motor_group", ~k[1:0] & 2'h3, motor_group);
      chk("speed_ref", 16'h1388 - 16'h00FA * k, speed_ref);
      rchk(`TCD_OFS_REF_OUT, 16'h1388 - 16'h00FA * k);
    end
    ahb(1'b1, `TCD_OFS_ROUTE, 32'h0000_0001);
    repeat (4) @(posedge core_clk);
    chk("pid_setpoint", 32'h0000_04E2, pid_setpoint);
    chk("speed_ref", 32'h0000_0000, speed_ref);
    ahb(1'b1, `TCD_OFS_ROUTE, 32'h0000_0002);
    repeat (4) @(posedge core_clk);
    chk("vf_voltage", 32'h0000_04E2, vf_voltage);
    chk("pid_setpoint", 32'h0000_0000, pid_setpoint);
    ahb(1'b1, `TCD_OFS_MAX_FREQ, 32'h0000_2710);
    repeat (4) @(posedge core_clk);
    chk("vf_voltage", 32'h0000_09C4, vf_voltage);
  endtask
  initial
  begin
    #(5 * 60000);
    miscompares = miscompares + 1;
    stop_test;
  end
  initial
  begin
    miscompares = 0;
    n_checks = 0;
    {rst_b, hsel, hwrite} = 3'h0;
    clk_en = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    hsel <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_filter;
    t_gating;
    t_two_line;
    t_three_line;
    t_select;
    repeat (10100) @(posedge core_clk);
    chk("run_cmd", 1'b0, run_cmd);
    stop_test;
  end
endmodule
